/* rtl/dcw_apb.sv */
// APB slave that decodes writes to the command word and muxes read data.
`timescale 1ns/10ps
`default_nettype none
module dcw_apb (
    input wire logic pclk, // Bus clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // Slave select.
    input wire logic penable, // Access phase.
    input wire logic pwrite, // Write direction.
    input wire logic [31:0] paddr, // Byte address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [15:0] cmd_rd, // Stored command word.
    input wire logic [2:0] mode_rd, // Stored operating mode.
    input wire logic [4:0] state_rd, // Drive state.
    output logic [31:0] prdata, // Read data.
    output logic pslverr, // Error for unmapped address.
    output logic mode_we, // Mode write strobe.
    dcw_wr_if.slave wr // Command word write strobe.
);
    logic acc;
    logic hit_cmd;
    logic hit_mode;
    logic hit_state;

    // Zero-wait slave: every access completes in its first access cycle.
    assign acc = psel && penable;
    assign hit_cmd = paddr[15:0] == dcw_pkg::DCW_CMD_OFS && paddr[31:16] == 16'h0000;
    assign hit_mode = paddr[15:0] == dcw_pkg::DCW_MODE_OFS && paddr[31:16] == 16'h0000;
    assign hit_state = paddr[15:0] == dcw_pkg::DCW_STATE_OFS && paddr[31:16] == 16'h0000;
    assign wr.cmd_we = acc && pwrite && hit_cmd;
    assign wr.cmd_wdata = pwdata[15:0];
    assign mode_we = acc && pwrite && hit_mode;
    assign pslverr = acc && !(hit_cmd || hit_mode || hit_state);

    // Read data registered in setup phase so it is a flop output in access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            if (hit_cmd)
                prdata <= {16'h0000, cmd_rd};
            else if (hit_mode)
                prdata <= {29'h00000000, mode_rd};
            else if (hit_state)
                prdata <= {27'h0000000, state_rd};
            else
                prdata <= 32'h00000000;
        end
    end
endmodule // dcw_apb
`default_nettype wire

/* rtl/dcw_pkg.sv */
// Package with register map, field positions and encodings of the drive command word decoder.
package dcw_pkg;
    localparam logic [15:0] DCW_CMD_OFS = 16'h6040;
    localparam logic [15:0] DCW_MODE_OFS = 16'h6060;
    localparam logic [15:0] DCW_STATE_OFS = 16'h6064;
    localparam logic [15:0] DCW_CMD_RST = 16'h0000;
    localparam logic [15:0] DCW_CMD_WMASK = 16'h3afb | 16'h0004;
    localparam logic [2:0] DCW_MODE_RST = 3'h0;
    localparam int DCW_B_SWON = 0;
    localparam int DCW_B_DISV = 1;
    localparam int DCW_B_QSTOP = 2;
    localparam int DCW_B_ENOP = 3;
    localparam int DCW_B_MS1 = 4;
    localparam int DCW_B_MS2 = 5;
    localparam int DCW_B_MS3 = 6;
    localparam int DCW_B_FRST = 7;
    localparam int DCW_B_MS4 = 9;
    localparam int DCW_B_DBRK = 11;
    localparam int DCW_B_NLIM = 12;
    localparam int DCW_B_PLIM = 13;
    localparam logic [15:0] DCW_W_SHUTDOWN = 16'h0006;
    localparam logic [15:0] DCW_W_SWITCHON = 16'h0007;
    localparam logic [2:0] DCW_MODE_JOG = 3'h1;
    localparam logic [2:0] DCW_MODE_HOME = 3'h2;
    typedef enum logic [4:0] {
        DCW_ST_DISABLED = 5'h01,
        DCW_ST_READY = 5'h02,
        DCW_ST_SWON = 5'h04,
        DCW_ST_OPEN = 5'h08,
        DCW_ST_FAULT = 5'h10
    } dcw_state_e;
endpackage

/* rtl/dcw_top.sv */
// Drive command word decoder with APB register access.
`timescale 1ns/10ps
`default_nettype none
module dcw_top (
    input wire logic pclk, // Clock, 100 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [31:0] paddr, // APB address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready, always high.
    output logic pslverr, // APB error.
    input wire logic fault_in, // Fault report from drive, same clock.
    output logic [4:0] drive_state, // One-hot drive state.
    output logic quick_stop, // Quick stop active level.
    output logic fault_reset, // One-cycle fault reset pulse.
    output logic [1:0] jog_speed_sel, // Jog speed selector.
    output logic jog_plus, // Positive jog request.
    output logic jog_minus, // Negative jog request.
    output logic home_run, // Homing routine active.
    output logic dyn_brake, // Dynamic brake active.
    output logic neg_limit, // Commanded negative limit.
    output logic pos_limit // Commanded positive limit.
);
    dcw_wr_if wr ();
    logic [15:0] cmd;
    logic [15:0] prev;
    logic [2:0] mode;
    logic mode_we;
    logic pend;
    logic [15:0] rise;
    logic in_jog;
    logic in_home;
    dcw_pkg::dcw_state_e state;
    dcw_pkg::dcw_state_e next_state;

    assign pready = 1'b1;

    dcw_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .cmd_rd(cmd),
        .mode_rd(mode),
        .state_rd(state),
        .prdata(prdata),
        .pslverr(pslverr),
        .mode_we(mode_we),
        .wr(wr)
    );

    // Reserved bits are masked on write so they always read back zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd <= dcw_pkg::DCW_CMD_RST;
        else if (wr.cmd_we)
            cmd <= wr.cmd_wdata & dcw_pkg::DCW_CMD_WMASK;
    end

    // Previous word is taken on each write so edges are judged per write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev <= dcw_pkg::DCW_CMD_RST;
            pend <= 1'b0;
        end
        else
        begin
            if (wr.cmd_we)
                prev <= cmd;
            pend <= wr.cmd_we;
        end
    end

    // Operating mode register, three bits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode <= dcw_pkg::DCW_MODE_RST;
        else if (mode_we)
            mode <= pwdata[2:0];
    end

    assign rise = pend ? (cmd & ~prev) : 16'h0000;
    assign in_jog = mode == dcw_pkg::DCW_MODE_JOG;
    assign in_home = mode == dcw_pkg::DCW_MODE_HOME;

    // State transitions; fault input first, then in fault only the fault reset edge, else whole-word commands before single-bit edges.
    always_comb
    begin
        next_state = state;
        if (fault_in)
            next_state = dcw_pkg::DCW_ST_FAULT;
        else if (state == dcw_pkg::DCW_ST_FAULT)
        begin
            if (rise[dcw_pkg::DCW_B_FRST])
                next_state = dcw_pkg::DCW_ST_DISABLED;
        end
        else if (pend && cmd == dcw_pkg::DCW_W_SHUTDOWN)
            next_state = dcw_pkg::DCW_ST_READY;
        else if (pend && cmd == dcw_pkg::DCW_W_SWITCHON)
            next_state = dcw_pkg::DCW_ST_SWON;
        else if (rise[dcw_pkg::DCW_B_DISV])
            next_state = dcw_pkg::DCW_ST_DISABLED;
        else if (rise[dcw_pkg::DCW_B_ENOP])
            next_state = dcw_pkg::DCW_ST_OPEN;
        else if (rise[dcw_pkg::DCW_B_SWON])
            next_state = dcw_pkg::DCW_ST_SWON;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= dcw_pkg::DCW_ST_DISABLED;
        else
            state <= next_state;
    end
    assign drive_state = state;

    // Fault reset pulses once per rising edge; holding the bit gives no repeat.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_reset <= 1'b0;
        else
            fault_reset <= rise[dcw_pkg::DCW_B_FRST];
    end

    // Level outputs follow the stored word; mode bits act only in their mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            quick_stop <= 1'b1;
            jog_speed_sel <= 2'h0;
            jog_plus <= 1'b0;
            jog_minus <= 1'b0;
            home_run <= 1'b0;
            dyn_brake <= 1'b0;
            neg_limit <= 1'b0;
            pos_limit <= 1'b0;
        end
        else
        begin
            quick_stop <= !cmd[dcw_pkg::DCW_B_QSTOP];
            jog_speed_sel[0] <= in_jog && cmd[dcw_pkg::DCW_B_MS1];
            jog_speed_sel[1] <= in_jog && cmd[dcw_pkg::DCW_B_MS4];
            jog_plus <= in_jog && cmd[dcw_pkg::DCW_B_MS2];
            jog_minus <= in_jog && cmd[dcw_pkg::DCW_B_MS3];
            home_run <= in_home && cmd[dcw_pkg::DCW_B_MS1];
            dyn_brake <= cmd[dcw_pkg::DCW_B_DBRK];
            neg_limit <= cmd[dcw_pkg::DCW_B_NLIM];
            pos_limit <= cmd[dcw_pkg::DCW_B_PLIM];
        end
    end

    // Checks on the decoded outputs and the stored command word.
    sw_on_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rise[0] && !rise[1] && !rise[3] && !fault_in && state != dcw_pkg::DCW_ST_FAULT
         && cmd != dcw_pkg::DCW_W_SHUTDOWN) |=> state == dcw_pkg::DCW_ST_SWON)
        else $error("switch on edge missed");
    dis_volt_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rise[1] && !fault_in && state != dcw_pkg::DCW_ST_FAULT && cmd != dcw_pkg::DCW_W_SHUTDOWN
         && cmd != dcw_pkg::DCW_W_SWITCHON) |=> state == dcw_pkg::DCW_ST_DISABLED)
        else $error("disable voltage edge missed");
    quick_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cmd[2] ##1 !$past(wr.cmd_we) |-> quick_stop)
        else $error("quick stop not active");
    en_op_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rise[3] && !rise[1] && !fault_in && state != dcw_pkg::DCW_ST_FAULT && cmd != dcw_pkg::DCW_W_SHUTDOWN
         && cmd != dcw_pkg::DCW_W_SWITCHON) |=> state == dcw_pkg::DCW_ST_OPEN)
        else $error("enable operation edge missed");
    jog_plus_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> jog_plus == $past(in_jog && cmd[5]))
        else $error("jog plus wrong");
    jog_minus_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> jog_minus == $past(in_jog && cmd[6]))
        else $error("jog minus wrong");
    fault_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        fault_reset |=> !fault_reset)
        else $error("fault reset repeated");
    resv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd & 16'hc500) == 16'h0000)
        else $error("reserved bits set");
    brake_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> dyn_brake == $past(cmd[11]))
        else $error("dynamic brake wrong");
    shutdown_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pend && cmd == 16'h0006 && !fault_in && state != dcw_pkg::DCW_ST_FAULT)
        |=> state == dcw_pkg::DCW_ST_READY)
        else $error("shutdown word ignored");
endmodule // dcw_top
`default_nettype wire

/* rtl/dcw_wr_if.sv */
// Interface carrying the decoded command word write strobe and data from the bus slave to the decoder.
`timescale 1ns/10ps
`default_nettype none
interface dcw_wr_if;
    logic cmd_we;
    logic [15:0] cmd_wdata;
    modport slave (output cmd_we, output cmd_wdata);
    modport core (input cmd_we, input cmd_wdata);
endinterface
`default_nettype wire

/* testbench/dcw_master.sv */
// Network master model that writes and reads drive command words over APB.
`timescale 1ns/10ps
`default_nettype none
module dcw_master (
    input wire logic pclk, // Bus clock.
    output logic psel, // Slave select.
    output logic penable, // Access phase.
    output logic pwrite, // Write direction.
    output logic [31:0] paddr, // Byte address.
    output logic [31:0] pwdata, // Write data.
    input wire logic pready, // Transfer done.
    input wire logic pslverr, // Transfer error.
    input wire logic [31:0] prdata // Read data.
);
    // The bus starts idle so nothing is requested before reset has gone.
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // One transfer, entered right after an edge; the request holds until pready is sampled high.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data lines show the inverse so a stale value cannot pass for a new one.
        pwdata <= ~d;
    endtask
endmodule // dcw_master
`default_nettype wire

/* testbench/test_dcw_top.sv */
// Self-checking bench for the drive command word decoder.
`timescale 1ns/10ps
`default_nettype none
module test_dcw_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_in, quick_stop, fault_reset, e;
    logic jog_plus, jog_minus, home_run, dyn_brake, neg_limit, pos_limit;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [4:0] drive_state;
    logic [1:0] jog_speed_sel;
    int err_count, comparisons;
    dcw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .drive_state(drive_state), .quick_stop(quick_stop), .fault_reset(fault_reset),
        .jog_speed_sel(jog_speed_sel), .jog_plus(jog_plus), .jog_minus(jog_minus), .home_run(home_run),
        .dyn_brake(dyn_brake), .neg_limit(neg_limit), .pos_limit(pos_limit));
    dcw_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Writes a word, then waits three edges where the one-edge decode latency needs one, leaving two to spare.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        m.xfer(1'b1, {16'h0, a}, {16'h0, d}, q, e);
        repeat (3) @(posedge pclk);
    endtask
    task automatic rd(input string n, input logic [15:0] a, input logic [31:0] exp);
        m.xfer(1'b0, {16'h0, a}, 32'h0, q, e);
        chk(n, exp, q);
        // One idle edge so the next request never re-raises psel in the same step.
        @(posedge pclk);
    endtask
    // Checks state plus quick stop, jog speed, jog plus, jog minus, homing, brake, limits.
    task automatic outs(input logic [4:0] st, input logic [8:0] o);
        #1;
        chk("outputs", {18'h0, st, o}, {18'h0, drive_state, quick_stop, jog_speed_sel, jog_plus,
            jog_minus, home_run, dyn_brake, neg_limit, pos_limit});
        @(posedge pclk);
    endtask
    // Writes a word and checks that fault reset pulses for exactly one cycle, or not at all.
    task automatic frw(input logic [15:0] d, input logic exp);
        m.xfer(1'b1, 32'h6040, {16'h0, d}, q, e);
        @(posedge pclk);
        #1;
        chk("fault_reset", {31'h0, exp}, {31'h0, fault_reset});
        @(posedge pclk);
        #1;
        chk("fault_reset end", 32'h0, {31'h0, fault_reset});
        @(posedge pclk);
    endtask
    // Main sequence: reset, state commands, fault, jog, homing, brake and bus errors.
    initial
    begin
        presetn = 1'b0;
        fault_in = 1'b0;
        err_count = 0;
        comparisons = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        outs(5'h01, 9'b1_00_000_000);
        rd("cmd reset", 16'h6040, 32'h0);
        wr(16'h6040, 16'h0006);
        outs(5'h02, 9'b0);
        wr(16'h6040, 16'h0007);
        outs(5'h04, 9'b0);
        wr(16'h6040, 16'h000f);
        outs(5'h08, 9'b0);
        wr(16'h6040, 16'h0004);
        wr(16'h6040, 16'h0002);
        outs(5'h01, 9'b1_00_000_000);
        wr(16'h6040, 16'h0005);
        outs(5'h04, 9'b0);
        fault_in <= 1'b1;
        repeat (3) @(posedge pclk);
        fault_in <= 1'b0;
        repeat (2) @(posedge pclk);
        outs(5'h10, 9'b0);
        frw(16'h0085, 1'b1);
        outs(5'h01, 9'b0);
        frw(16'h0085, 1'b0);
        wr(16'h6060, 16'h0001);
        wr(16'h6040, 16'h0274);
        outs(5'h01, 9'b0_11_110_000);
        wr(16'h6040, 16'h0004);
        outs(5'h01, 9'b0);
        wr(16'h6060, 16'h0002);
        wr(16'h6040, 16'h001f);
        chk("home_run on", 32'h1, {31'h0, home_run});
        wr(16'h6040, 16'h000f);
        chk("home_run off", 32'h0, {31'h0, home_run});
        wr(16'h6060, 16'h0000);
        wr(16'h6040, 16'hfd04);
        rd("cmd reserved", 16'h6040, 32'h3804);
        chk("brake limits", 32'h7, {29'h0, dyn_brake, neg_limit, pos_limit});
        rd("state reg", 16'h6064, 32'h1);
        rd("mode reg", 16'h6060, 32'h0);
        chk("pready", 32'h1, {31'h0, pready});
        m.xfer(1'b0, 32'h0010, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        report_and_stop();
    end
    // Cuts a hang short; the sequence needs well under a thousand cycles.
    initial
    begin
        #100000;
        err_count++;
        report_and_stop();
    end
endmodule // test_dcw_top
`default_nettype wire
